// >>> src/fbus_slave.sv
// Slave end: datagram interpreter, local memory, state gating, return FIFO.
// Assumes one datagram per frame and a master that waits for each state
// change to finish before asking for the next.
`timescale 1ns/1ns

module fbus_slave #(
  parameter int MEM_DEPTH = 64
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          ce,
  fbus_if.dev                link,
  input  wire logic [15:0]   station_addr,
  input  wire logic [31:0]   log_base,
  input  wire logic [15:0]   log_len,
  input  wire logic [15:0]   phys_base,
  input  wire logic          tool_any_state,
  input  wire logic          drive_step_up,
  input  wire logic          drive_shutdown,
  input  wire logic          fault_reset,
  input  wire logic          decel_done,
  input  wire logic [15:0]   usr_addr,
  output logic [7:0]         usr_rdata,
  output logic               mbx_en,
  output logic               pdo_tx_en,
  output logic               pdo_rx_en,
  output logic               tool_permit,
  output fbus_pkg::pds_type  pds_state
);
  import fbus_pkg::*;

  logic [7:0]  mem [MEM_DEPTH];
  logic [11:0] pos_q;
  logic        hi_ok_q, etype_ok_q, fb_q, carry_q, rd_seen_q, wr_seen_q;
  logic [7:0]  cmd_q;
  logic [15:0] adp_q, ado_q;
  logic [10:0] len_q;
  logic [3:0]  al_q, target_q;
  logic        busy_q, err_q;
  pds_type     pds_q;
  logic        take, in_data, ok, do_rd, do_wr, is_log, is_auto;
  logic [11:0] idx, wkc_pos;
  logic [15:0] addr;
  logic [31:0] laddr, loff;
  acc_type     mode;
  logic [7:0]  out_b;
  logic        fifo_ready;

  // Access type per command; reserved codes and no-op fall to none
  function automatic acc_type decode(input logic [7:0] c, input logic zero,
                                     input logic match, input logic hit);
    unique case (c)
      CMD_APRD: decode = zero ? ACC_RD : ACC_NONE;
      CMD_APWR: decode = zero ? ACC_WR : ACC_NONE;
      CMD_APRW: decode = zero ? ACC_RW : ACC_NONE;
      CMD_FPRD: decode = match ? ACC_RD : ACC_NONE;
      CMD_FPWR: decode = match ? ACC_WR : ACC_NONE;
      CMD_FPRW: decode = match ? ACC_RW : ACC_NONE;
      CMD_BRD:  decode = ACC_RD;
      CMD_BWR:  decode = ACC_WR;
      CMD_BRW:  decode = ACC_RW;
      CMD_LRD:  decode = hit ? ACC_RD : ACC_NONE;
      CMD_LWR:  decode = hit ? ACC_WR : ACC_NONE;
      CMD_LRW:  decode = hit ? ACC_RW : ACC_NONE;
      CMD_ARMW: decode = zero ? ACC_RD : ACC_WR;
      CMD_FRMW: decode = match ? ACC_RD : ACC_WR;
      default:  decode = ACC_NONE;
    endcase
  endfunction

  assign take = ce && link.tx_valid && fifo_ready;
  assign link.tx_ready = fifo_ready;
  assign is_log  = cmd_q == CMD_LRD || cmd_q == CMD_LWR || cmd_q == CMD_LRW;
  assign is_auto = cmd_q == CMD_APRD || cmd_q == CMD_APWR ||
                   cmd_q == CMD_APRW || cmd_q == CMD_ARMW;

  // Per-byte decision: address, gating and the byte sent back
  always_comb begin
    idx     = pos_q - POS_DATA;
    wkc_pos = POS_DATA + {1'b0, len_q};
    in_data = pos_q >= POS_DATA && pos_q < wkc_pos;
    laddr   = {ado_q, adp_q} + {20'h0, idx};
    loff    = laddr - log_base;
    addr    = is_log ? phys_base + loff[15:0] : ado_q + {4'h0, idx};
    mode    = ACC_NONE;
    if (fb_q && in_data) begin
      mode = decode(cmd_q, adp_q == 16'h0000, adp_q == station_addr,
                    laddr >= log_base && loff < {16'h0, log_len});
    end
    // Registers always open; other areas follow the gate flags
    ok = addr < 16'(MEM_DEPTH) &&
         (addr < REG_END ||
          (addr < MBX_END ? mbx_en :
           addr < PDO_RX_END ? pdo_rx_en : pdo_tx_en));
    do_rd = ok && (mode == ACC_RD || mode == ACC_RW);
    do_wr = ok && (mode == ACC_WR || mode == ACC_RW);
    out_b = link.tx_data;
    if (fb_q && is_auto && pos_q == POS_ADP_LO) begin
      out_b = link.tx_data + 8'h01;
    end else if (fb_q && is_auto && pos_q == POS_ADP_HI) begin
      out_b = link.tx_data + {7'h00, carry_q};
    end else if (do_rd) begin
      out_b = mem[addr[$clog2(MEM_DEPTH)-1:0]];
    end else if (fb_q && pos_q == wkc_pos) begin
      // Working counter: read adds one, write adds two
      out_b = link.tx_data + {6'h00, wr_seen_q, rd_seen_q};
    end else if (fb_q && pos_q == wkc_pos + 12'h001) begin
      out_b = link.tx_data + {7'h00, carry_q};
    end
  end

  // Frame parser state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pos_q <= '0; hi_ok_q <= 1'b0; etype_ok_q <= 1'b0; fb_q <= 1'b0;
      cmd_q <= CMD_NOP; adp_q <= '0; ado_q <= '0; len_q <= '0;
      carry_q <= 1'b0; rd_seen_q <= 1'b0; wr_seen_q <= 1'b0;
    end else if (take) begin
      pos_q <= link.tx_last ? 12'h000 : pos_q + 12'h001;
      unique case (pos_q)
        POS_ETYPE_HI: hi_ok_q <= link.tx_data == ETYPE_HI;
        POS_ETYPE_LO: etype_ok_q <= hi_ok_q && link.tx_data == ETYPE_LO;
        POS_HDR_HI:   fb_q <= etype_ok_q &&
                              link.tx_data[7:4] == FRAME_TYPE;
        POS_CMD:      cmd_q <= link.tx_data;
        POS_ADP_LO:   adp_q[7:0] <= link.tx_data;
        POS_ADP_HI:   adp_q[15:8] <= link.tx_data;
        POS_ADO_LO:   ado_q[7:0] <= link.tx_data;
        POS_ADO_HI:   ado_q[15:8] <= link.tx_data;
        POS_LEN_LO:   len_q[7:0] <= link.tx_data;
        POS_LEN_HI:   len_q[10:8] <= link.tx_data[2:0];
        default: ;
      endcase
      // Carry into the high byte of an incremented field
      carry_q <= out_b == 8'h00 && out_b != link.tx_data;
      if (do_rd) rd_seen_q <= 1'b1;
      if (do_wr) wr_seen_q <= 1'b1;
      if (link.tx_last) begin
        fb_q <= 1'b0; hi_ok_q <= 1'b0; etype_ok_q <= 1'b0;
        rd_seen_q <= 1'b0; wr_seen_q <= 1'b0;
      end
    end
  end

  // Local memory; old contents are read before a read-write overwrites
  always_ff @(posedge clk_sys) begin
    if (take && do_wr) mem[addr[$clog2(MEM_DEPTH)-1:0]] <= link.tx_data;
  end

  // Drive-side read port
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) usr_rdata <= 8'h00;
    else if (ce) usr_rdata <= mem[usr_addr[$clog2(MEM_DEPTH)-1:0]];
  end

  // Application-layer state with the power state it is coupled to
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      al_q <= AL_INIT; target_q <= AL_INIT; busy_q <= 1'b0; err_q <= 1'b0;
      pds_q <= PDS_NOT_READY;
    end else if (ce) begin
      if (link.al_req_valid && !busy_q) begin
        if (pds_q == PDS_OP_EN && link.al_req_state != al_q) begin
          err_q    <= 1'b1;
          pds_q    <= PDS_FAULT_REACT;
          busy_q   <= 1'b1;
          target_q <= link.al_req_state;
        end else begin
          al_q <= link.al_req_state;
          if (link.al_req_state == AL_INIT && al_q != AL_INIT) begin
            pds_q <= PDS_SW_DIS;
          end
        end
      end else if (busy_q) begin
        // Old state holds until the drive has stopped
        if (decel_done) begin
          al_q   <= target_q;
          busy_q <= 1'b0;
          pds_q  <= PDS_FAULT;
        end
      end else if (pds_q == PDS_NOT_READY) begin
        pds_q <= PDS_SW_DIS;
      end else if (fault_reset && pds_q == PDS_FAULT) begin
        pds_q <= PDS_SW_DIS;
      end else if (drive_shutdown && pds_q != PDS_FAULT) begin
        pds_q <= PDS_SW_DIS;
      end else if (drive_step_up) begin
        if (pds_q == PDS_SW_DIS && al_q != AL_INIT) pds_q <= PDS_READY;
        else if (pds_q == PDS_READY) pds_q <= PDS_SW_ON;
        else if (pds_q == PDS_SW_ON && al_q == AL_OP) pds_q <= PDS_OP_EN;
      end
    end
  end

  // Gates registered from the state; one cycle behind a state change
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mbx_en <= 1'b0; pdo_tx_en <= 1'b0; pdo_rx_en <= 1'b0;
      tool_permit <= 1'b0;
    end else if (ce) begin
      mbx_en    <= al_q == AL_PREOP || al_q == AL_SAFEOP ||
                   al_q == AL_OP;
      pdo_tx_en <= al_q == AL_SAFEOP || al_q == AL_OP;
      pdo_rx_en <= al_q == AL_OP;
      tool_permit <= tool_any_state || al_q == AL_INIT;
    end
  end

  assign link.al_state = al_q;
  assign link.al_busy  = busy_q;
  assign link.al_err   = err_q;
  assign pds_state     = pds_q;

  fbus_fifo #(.W(9), .DEPTH(16)) ret_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_data   ({link.tx_last, out_b}),
    .in_valid  (link.tx_valid),
    .in_ready  (fifo_ready),
    .out_data  ({link.rx_last, link.rx_data}),
    .out_valid (link.rx_valid),
    .out_ready (link.rx_ready)
  );
endmodule

// >>> src/fbus_pkg.sv
// Shared constants and types for the fieldbus slave and master ends.
// Assumes a byte-wide frame stream, least significant byte first in fields.
package fbus_pkg;
  // Ethernet and fieldbus frame header
  localparam logic [7:0]  ETYPE_HI       = 8'h88;
  localparam logic [7:0]  ETYPE_LO       = 8'ha4;
  localparam logic [3:0]  FRAME_TYPE     = 4'h1;
  localparam int          MIN_FRAME_B    = 64;   // Including FCS
  localparam int          FCS_B          = 4;
  localparam logic [11:0] PAD_LAST_POS   = 12'(MIN_FRAME_B - FCS_B - 1);
  // Byte positions inside a frame carrying one datagram
  localparam logic [11:0] POS_ETYPE_HI   = 12'h00c;
  localparam logic [11:0] POS_ETYPE_LO   = 12'h00d;
  localparam logic [11:0] POS_HDR_HI     = 12'h00f;
  localparam logic [11:0] POS_CMD        = 12'h010;
  localparam logic [11:0] POS_ADP_LO     = 12'h012;
  localparam logic [11:0] POS_ADP_HI     = 12'h013;
  localparam logic [11:0] POS_ADO_LO     = 12'h014;
  localparam logic [11:0] POS_ADO_HI     = 12'h015;
  localparam logic [11:0] POS_LEN_LO     = 12'h016;
  localparam logic [11:0] POS_LEN_HI     = 12'h017;
  localparam logic [11:0] POS_DATA       = 12'h01a;
  // Datagram command codes
  localparam logic [7:0]  CMD_NOP  = 8'h00;
  localparam logic [7:0]  CMD_APRD = 8'h01;
  localparam logic [7:0]  CMD_APWR = 8'h02;
  localparam logic [7:0]  CMD_APRW = 8'h03;
  localparam logic [7:0]  CMD_FPRD = 8'h04;
  localparam logic [7:0]  CMD_FPWR = 8'h05;
  localparam logic [7:0]  CMD_FPRW = 8'h06;
  localparam logic [7:0]  CMD_BRD  = 8'h07;
  localparam logic [7:0]  CMD_BWR  = 8'h08;
  localparam logic [7:0]  CMD_BRW  = 8'h09;
  localparam logic [7:0]  CMD_LRD  = 8'h0a;
  localparam logic [7:0]  CMD_LWR  = 8'h0b;
  localparam logic [7:0]  CMD_LRW  = 8'h0c;
  localparam logic [7:0]  CMD_ARMW = 8'h0d;
  localparam logic [7:0]  CMD_FRMW = 8'h0e;
  // Application-layer state codes
  localparam logic [3:0]  AL_INIT   = 4'h1;
  localparam logic [3:0]  AL_PREOP  = 4'h2;
  localparam logic [3:0]  AL_BOOT   = 4'h3;
  localparam logic [3:0]  AL_SAFEOP = 4'h4;
  localparam logic [3:0]  AL_OP     = 4'h8;
  // Slave memory regions by physical address
  localparam logic [15:0] REG_END    = 16'h0010;
  localparam logic [15:0] MBX_END    = 16'h0020;
  localparam logic [15:0] PDO_RX_END = 16'h0030;
  // Master state-request timeout
  localparam int          CLK_KHZ        = 50000;
  localparam int          STATE_TMO_MS   = 1000;
  localparam int          STATE_TMO_CYC  = CLK_KHZ * STATE_TMO_MS;

  typedef enum logic [1:0] {ACC_NONE, ACC_RD, ACC_WR, ACC_RW} acc_type;
  typedef enum logic [2:0] {
    PDS_NOT_READY, PDS_SW_DIS, PDS_READY, PDS_SW_ON, PDS_OP_EN,
    PDS_FAULT_REACT, PDS_FAULT
  } pds_type;
endpackage

// >>> src/fbus_if.sv
// Link between the fieldbus master end and the slave end.
// Byte stream out and back, plus state request and state report lines.
`timescale 1ns/1ns
interface fbus_if;
  logic [7:0] tx_data;
  logic       tx_last;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_last;
  logic       rx_valid;
  logic       rx_ready;
  logic       al_req_valid;
  logic [3:0] al_req_state;
  logic [3:0] al_state;
  logic       al_busy;
  logic       al_err;

  modport dev (
    input  tx_data, tx_last, tx_valid, rx_ready, al_req_valid, al_req_state,
    output tx_ready, rx_data, rx_last, rx_valid, al_state, al_busy, al_err
  );
  modport mst (
    output tx_data, tx_last, tx_valid, rx_ready, al_req_valid, al_req_state,
    input  tx_ready, rx_data, rx_last, rx_valid, al_state, al_busy, al_err
  );
endinterface

// >>> src/fbus_master.sv
// Master end: tags and pads outgoing frames, sequences state requests.
// Also holds the return-path FIFO that the slave end instantiates.
// Assumes the user gives header and data without FCS, one byte a cycle.
`timescale 1ns/1ns
module fbus_master #(
  parameter int TMO_CYC = fbus_pkg::STATE_TMO_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ce,
  fbus_if.mst              link,
  input  wire logic [7:0]  usr_data,
  input  wire logic        usr_last,
  input  wire logic        usr_valid,
  output logic             usr_ready,
  output logic [7:0]       rcv_data,
  output logic             rcv_last,
  output logic             rcv_valid,
  input  wire logic        rcv_ready,
  input  wire logic        state_req,
  input  wire logic [3:0]  state_target,
  output logic             req_busy,
  output logic             req_timeout,
  output logic             keep_cyclic,
  output logic             power_enable_ok,
  output logic [3:0]       cur_state
);
  import fbus_pkg::*;

  typedef enum logic {M_SEND, M_PAD} mstate_type;
  mstate_type  st_q;
  logic [11:0] cnt_q;
  logic [7:0]  data_q;
  logic        last_q, valid_q, slot, req_q;
  logic [3:0]  target_q;
  logic [31:0] tmo_q;

  // Output slot frees when the slave takes the byte
  assign slot      = !valid_q || link.tx_ready;
  assign usr_ready = ce && slot && st_q == M_SEND;

  // Frame sender with type tagging and padding
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= M_SEND; cnt_q <= '0; data_q <= 8'h00;
      last_q <= 1'b0; valid_q <= 1'b0;
    end else if (ce && slot) begin
      valid_q <= 1'b0;
      if (st_q == M_SEND && usr_valid) begin
        valid_q <= 1'b1;
        data_q  <= cnt_q == POS_ETYPE_HI ? ETYPE_HI :
                   cnt_q == POS_ETYPE_LO ? ETYPE_LO : usr_data;
        last_q  <= usr_last && cnt_q >= PAD_LAST_POS;
        cnt_q   <= cnt_q + 12'h001;
        if (usr_last && cnt_q < PAD_LAST_POS) st_q <= M_PAD;
        else if (usr_last) cnt_q <= 12'h000;
      end else if (st_q == M_PAD) begin
        valid_q <= 1'b1;
        data_q  <= 8'h00;
        last_q  <= cnt_q == PAD_LAST_POS;
        cnt_q   <= cnt_q == PAD_LAST_POS ? 12'h000 : cnt_q + 12'h001;
        if (cnt_q == PAD_LAST_POS) st_q <= M_SEND;
      end
    end
  end

  // State requests: one at a time, done when reported and not busy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= 1'b0; req_busy <= 1'b0; target_q <= AL_INIT;
      tmo_q <= '0; req_timeout <= 1'b0; keep_cyclic <= 1'b0;
    end else if (ce) begin
      req_q <= 1'b0;
      if (state_req && !req_busy) begin
        req_q       <= 1'b1;
        req_busy    <= 1'b1;
        target_q    <= state_target;
        tmo_q       <= '0;
        req_timeout <= 1'b0;
        keep_cyclic <= link.al_state == AL_OP;
      end else if (req_busy && !req_q) begin
        tmo_q <= tmo_q + 32'h1;
        if (link.al_state == target_q && !link.al_busy) begin
          req_busy    <= 1'b0;
          keep_cyclic <= 1'b0;
        end else if (tmo_q >= 32'(TMO_CYC - 1)) begin
          req_busy    <= 1'b0;
          req_timeout <= 1'b1;
          keep_cyclic <= 1'b0;
        end
      end
    end
  end

  // Status mirrors
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_enable_ok <= 1'b0;
      cur_state       <= AL_INIT;
    end else if (ce) begin
      power_enable_ok <= link.al_state == AL_OP && !link.al_busy;
      cur_state       <= link.al_state;
    end
  end

  assign link.tx_data      = data_q;
  assign link.tx_last      = last_q;
  assign link.tx_valid     = valid_q;
  assign link.al_req_valid = req_q;
  assign link.al_req_state = target_q;
  assign link.rx_ready     = rcv_ready;
  assign rcv_data          = link.rx_data;
  assign rcv_last          = link.rx_last;
  assign rcv_valid         = link.rx_valid;
endmodule

// Return-path FIFO; stalls the frame parser when full
module fbus_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Full and empty come from the occupancy count alone
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Pointers and count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= AW'((wr_q + 1'b1) % DEPTH);
      if (pop) rd_q <= AW'((rd_q + 1'b1) % DEPTH);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset; only valid entries are ever read out
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_q] <= in_data;
  end
endmodule

// >>> tb/fbus_props.sv
// Link checker for the fieldbus master and slave ends.
// Assumes ce is held high, so every handshake on the link counts.
`timescale 1ns/1ns
module fbus_props
  import fbus_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       al_req_valid,
  input wire logic [3:0] al_req_state,
  input wire logic [3:0] al_state,
  input wire logic       al_busy,
  input wire logic       al_err
);
  logic [11:0] bc_q;
  wire         tk = tx_valid && tx_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Byte index on the wire; the last byte restarts it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      bc_q <= 12'h000;
    else if (tk)
      bc_q <= tx_last ? 12'h000 : bc_q + 12'h001;
  end
  chk_type_high: assert property (tk && bc_q == POS_ETYPE_HI |->
    tx_data == ETYPE_HI) else $error("type high byte wrong");
  chk_type_low: assert property (tk && bc_q == POS_ETYPE_LO |->
    tx_data == ETYPE_LO) else $error("type low byte wrong");
  chk_pad_len: assert property (tk && tx_last |->
    bc_q >= PAD_LAST_POS) else $error("frame ends short");
  chk_rx_answer: assert property (tk |=> rx_valid)
    else $error("byte not returned");
  chk_rx_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data)) else $error("return byte dropped");
  chk_req_taken: assert property (al_req_valid && !al_busy |=>
    al_busy || al_state == $past(al_req_state)) else $error("req lost");
  chk_busy_op: assert property (al_busy |->
    al_state == AL_OP && al_err) else $error("busy outside op");
  chk_err_sticky: assert property (al_err |=> al_err)
    else $error("error flag cleared");
  chk_err_busy: assert property ($rose(al_err) |-> al_busy)
    else $error("error without wait");
endmodule

// >>> tb/fbus_slave_datagram_esm_tb.sv
// Bench: master end and slave end joined back to back over the link.
// Assumes the hand-over latencies; ce held high throughout.
`timescale 1ns/1ns
module fbus_slave_datagram_esm_tb;
  import fbus_pkg::*;
  logic        clk_sys, rst_b, usr_last, usr_valid, usr_ready, rcv_last;
  logic        rcv_valid, rcv_ready, state_req, stall, step, fres, decel;
  logic        tool, mbx_en, pdo_tx_en, pdo_rx_en, tool_permit, pw_ok;
  logic [7:0]  usr_data, rcv_data, usr_rdata, fr[60], rv[60];
  logic [15:0] usr_addr, sa = 16'h1001, ll = 16'h0004, pb = 16'h0008;
  logic [31:0] lb = 32'h0001_0000;
  logic [3:0]  state_target, cst;
  logic        rbusy, rtmo, kc;
  pds_type     pds;
  int          err_total, checks_done, n;
  fbus_if lk();
  fbus_master #(.TMO_CYC(64)) i_fbus_master (.clk_sys, .rst_b, .ce(1'b1),
    .link(lk), .usr_data, .usr_last, .usr_valid, .usr_ready, .rcv_data,
    .rcv_last, .rcv_valid, .rcv_ready, .state_req, .state_target,
    .req_busy(rbusy), .req_timeout(rtmo), .keep_cyclic(kc),
    .power_enable_ok(pw_ok), .cur_state(cst));
  fbus_slave i_fbus_slave (.clk_sys, .rst_b, .ce(1'b1), .link(lk),
    .station_addr(sa), .log_base(lb), .log_len(ll), .phys_base(pb),
    .tool_any_state(tool), .drive_step_up(step), .drive_shutdown(1'b0),
    .fault_reset(fres), .decel_done(decel), .usr_addr, .usr_rdata, .mbx_en,
    .pdo_tx_en, .pdo_rx_en, .tool_permit, .pds_state(pds));
  fbus_props i_fbus_props (.clk_sys, .rst_b, .tx_data(lk.tx_data),
    .tx_last(lk.tx_last), .tx_valid(lk.tx_valid), .tx_ready(lk.tx_ready),
    .rx_data(lk.rx_data), .rx_valid(lk.rx_valid), .rx_ready(lk.rx_ready),
    .al_req_valid(lk.al_req_valid), .al_req_state(lk.al_req_state),
    .al_state(lk.al_state), .al_busy(lk.al_busy), .al_err(lk.al_err));
  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a handshake flag, looked at mid-cycle to avoid races
  task automatic wt(ref logic s);
    int k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (s !== 1'b1 && k < 300);
    if (k >= 300) begin
      err_total++;
      wrap_up();
    end
  endtask
  // One datagram frame out and back; stall holds the return path shut
  task automatic run(input logic [7:0] c, input logic [15:0] adp, ado,
    input logic [7:0] d, ed, input logic [15:0] ew, ea,
    input logic [3:0] h = 4'h1);
    foreach (fr[i]) fr[i] = 8'h00;
    fr[15] = {h, 4'h0};
    fr[16] = c;
    {fr[19], fr[18], fr[21], fr[20]} = {adp, ado};
    fr[22] = 8'h01;
    fr[26] = d;
    n = 0;
    rcv_ready <= !stall;
    fork
      begin
        for (int i = 0; i < 29; i++) begin
          usr_data <= fr[i];
          usr_last <= i == 28;
          usr_valid <= 1'b1;
          wt(usr_ready);
          @(posedge clk_sys);
        end
        usr_valid <= 1'b0;
      end
      begin
        if (stall) begin
          repeat (40) @(negedge clk_sys);
          chk(lk.tx_ready, 1'b0);
          @(posedge clk_sys);
          rcv_ready <= 1'b1;
        end
        do begin
          wt(rcv_valid);
          rv[n] = rcv_data;
          n++;
        end while (rcv_last !== 1'b1 && n < 60);
        chk(rcv_last, 1'b1);
      end
    join
    @(posedge clk_sys);
    chk(n, 60);
    chk({rv[12], rv[13]}, {ETYPE_HI, ETYPE_LO});
    chk({rv[26], rv[28], rv[27], rv[19], rv[18]}, {ed, ew, ea});
  endtask
  // State request through the master end
  task automatic go(input logic [3:0] t);
    state_req <= 1'b1;
    state_target <= t;
    @(posedge clk_sys);
    state_req <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  // Current state and its gates {mailbox, pdo out, pdo in, tool}
  task automatic gates(input logic [3:0] s, g);
    @(negedge clk_sys);
    chk({lk.al_state, mbx_en, pdo_tx_en, pdo_rx_en, tool_permit}, {s, g});
    @(posedge clk_sys);
  endtask
  initial begin
    {rst_b, usr_valid, usr_last, usr_data, state_req, step} = '0;
    {fres, decel, tool, err_total, checks_done} = '0;
    {rcv_ready, stall, usr_addr, state_target} = {2'b11, 16'h0004, AL_INIT};
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    gates(AL_INIT, 4'b0001);
    run(CMD_FPWR, 16'h1001, 16'h0002, 8'h5a, 8'h5a, 16'h2, 16'h1001);
    stall = 1'b0;
    run(CMD_FPWR, 16'h1002, 16'h0002, 8'h11, 8'h11, 16'h0, 16'h1002);
    run(CMD_FPRD, 16'h1001, 16'h0002, 8'h00, 8'h5a, 16'h1, 16'h1001);
    run(CMD_FPRW, 16'h1001, 16'h0002, 8'h33, 8'h5a, 16'h3, 16'h1001);
    run(CMD_APWR, 16'h0000, 16'h0003, 8'h44, 8'h44, 16'h2, 16'h0001);
    run(CMD_APRD, 16'hffff, 16'h0003, 8'h00, 8'h00, 16'h0, 16'h0000);
    run(CMD_APRD, 16'h0000, 16'h0003, 8'h00, 8'h44, 16'h1, 16'h0001);
    run(CMD_APRW, 16'h0000, 16'h0003, 8'h55, 8'h44, 16'h3, 16'h0001);
    run(CMD_BWR, 16'h0007, 16'h0004, 8'h66, 8'h66, 16'h2, 16'h0007);
    run(CMD_BRD, 16'h0007, 16'h0004, 8'h00, 8'h66, 16'h1, 16'h0007);
    run(CMD_BRW, 16'h0007, 16'h0004, 8'h77, 8'h66, 16'h3, 16'h0007);
    run(CMD_NOP, 16'h0000, 16'h0004, 8'h99, 8'h99, 16'h0, 16'h0000);
    chk(usr_rdata, 8'h77);
    run(CMD_ARMW, 16'h0000, 16'h0003, 8'haa, 8'h55, 16'h1, 16'h0001);
    run(CMD_ARMW, 16'h0005, 16'h0003, 8'haa, 8'haa, 16'h2, 16'h0006);
    run(CMD_FRMW, 16'h1001, 16'h0003, 8'hbb, 8'haa, 16'h1, 16'h1001);
    run(CMD_FRMW, 16'h2222, 16'h0003, 8'hbb, 8'hbb, 16'h2, 16'h2222);
    run(8'h0f, 16'h0000, 16'h0003, 8'hcc, 8'hcc, 16'h0, 16'h0000);
    run(CMD_FPWR, 16'h1001, 16'h3, 8'hcc, 8'hcc, '0, 16'h1001, 4'h2);
    run(CMD_FPRD, 16'h1001, 16'h0003, 8'h00, 8'hbb, 16'h1, 16'h1001);
    run(CMD_LWR, 16'h0002, 16'h0001, 8'hde, 8'hde, 16'h2, 16'h0002);
    run(CMD_LRD, 16'h0002, 16'h0001, 8'h00, 8'hde, 16'h1, 16'h0002);
    run(CMD_LRW, 16'h0002, 16'h0001, 8'hef, 8'hde, 16'h3, 16'h0002);
    run(CMD_LRD, 16'h0004, 16'h0001, 8'h00, 8'h00, 16'h0, 16'h0004);
    run(CMD_BWR, 16'h0000, 16'h0012, 8'h12, 8'h12, 16'h0, 16'h0000);
    run(CMD_BWR, 16'h0000, 16'h0002, 8'h12, 8'h12, 16'h2, 16'h0000);
    go(AL_PREOP);
    gates(AL_PREOP, 4'b1000);
    run(CMD_BWR, 16'h0000, 16'h0012, 8'h12, 8'h12, 16'h2, 16'h0000);
    go(AL_SAFEOP);
    gates(AL_SAFEOP, 4'b1100);
    chk(pw_ok, 1'b0);
    run(CMD_BWR, 16'h0000, 16'h0022, 8'h22, 8'h22, 16'h0, 16'h0000);
    run(CMD_BWR, 16'h0000, 16'h0032, 8'h32, 8'h32, 16'h2, 16'h0000);
    tool <= 1'b1;
    go(AL_OP);
    gates(AL_OP, 4'b1111);
    chk(pw_ok, 1'b1);
    run(CMD_BWR, 16'h0000, 16'h0022, 8'h22, 8'h22, 16'h2, 16'h0000);
    // Power the drive up, then ask to leave while it runs
    step <= 1'b1;
    repeat (4) @(posedge clk_sys);
    step <= 1'b0;
    go(AL_PREOP);
    @(negedge clk_sys);
    chk({lk.al_state, lk.al_busy, lk.al_err, pds},
      {AL_OP, 2'b11, PDS_FAULT_REACT});
    chk(pw_ok, 1'b0);
    chk({kc, rbusy}, 2'b11);
    // Hold the drive past the master's limit so its timeout must fire
    repeat (64) @(posedge clk_sys);
    chk({rtmo, lk.al_busy, lk.al_state}, {2'b11, AL_OP});
    @(posedge clk_sys);
    decel <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({lk.al_state, lk.al_busy, pds, cst},
      {AL_PREOP, 1'b0, PDS_FAULT, AL_PREOP});
    {decel, fres} <= 2'b01;
    @(posedge clk_sys);
    {fres, step} <= 2'b01;
    @(posedge clk_sys);
    step <= 1'b0;
    go(AL_INIT);
    chk(pds, PDS_SW_DIS);
    gates(AL_INIT, 4'b0001);
    wrap_up();
  end
endmodule
